// *** rtl/dcsl_top.sv ***
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module dcsl_top #(
	parameter int UNITS = 8
) (
	// Clock and reset.
	input  wire logic                   CLOCK_IN,
	input  wire logic                   SRST_IN,
	// Avalon-MM slave.
	input  wire logic [5:0]             AVS_ADDRESS_IN,
	input  wire logic                   AVS_READ_IN,
	input  wire logic                   AVS_WRITE_IN,
	input  wire logic [31:0]            AVS_WRITEDATA_IN,
	input  wire logic [3:0]             AVS_BYTEENABLE_IN,
	output logic      [31:0]            AVS_READDATA_OUT,
	output logic                        AVS_WAITREQUEST_OUT,
	// Panel switches.
	input  wire logic                   LOCKOUT_SW_IN,
	input  wire logic [2:0]             PROTECTED_UNIT_IN,
	input  wire logic [2:0]             PROTECT_LIMIT_CYL_IN,
	input  wire logic                   FORMAT_SW_IN,
	// Drive reports: per-unit vectors, then the selected drive's head cylinder.
	input  wire logic [UNITS-1:0]       DRV_ONLINE_IN,
	input  wire logic [UNITS-1:0]       DRV_READY_IN,
	input  wire logic [UNITS-1:0]       DRV_SEEKING_IN,
	input  wire logic [UNITS-1:0]       DRV_READ_ONLY_IN,
	input  wire logic [UNITS-1:0]       DRV_POS_DONE_IN,
	input  wire logic [7:0]             DRV_HEAD_POS_IN,
	// Data path word strobe.
	input  wire logic                   WORD_STROBE_IN,
	// Drive commands and state.
	output logic [2:0]                  UNIT_SELECT_OUT,
	output logic [7:0]                  CYLINDER_ADDRESS_OUT,
	output logic [4:0]                  HEAD_ADDRESS_OUT,
	output logic [16:0]                 MEMORY_ADDRESS_OUT,
	output logic                        HEAD_CLEAR_OUT,
	output logic                        HEAD_STEP_OUT,
	output logic                        SEEK_START_OUT,
	output logic                        RECAL_START_OUT,
	output logic                        READ_ENABLE_OUT,
	output logic                        WRITE_ENABLE_OUT,
	output logic                        BUSY_OUT,
	output logic                        ATTENTION_OUT,
	output logic                        UNIT_WRITE_BLOCKED_OUT
);

	// All state of the block.
	typedef struct packed {
		dcsl_pkg::dcsl_state_type state;
		logic [2:0]               unit_sel;
		logic [2:0]               func;
		logic [16:0]              mem_addr;
		logic [7:0]               cyl;
		logic [4:0]               head;
		logic [3:0]               sector;
		logic [7:0]               drv_pos;
		logic [7:0]               attn;
		logic                     attn_any;
		logic [6:0]               sector_word_counter;
		logic                     swc_ovf;
		logic [8:0]               format_sequencer_state;
		logic                     online;
		logic                     ready;
		logic                     seeking;
		logic                     read_only;
		logic                     blocked;
		logic                     wp_err;
		logic                     busy;
		logic                     waitreq;
		logic [31:0]              rdata;
		// Drive strobes live in flops so no decode gates sit on the pins.
		logic                     head_clr;
		logic                     head_step;
		logic                     seek_go;
		logic                     recal_go;
		logic                     rd_en;
		logic                     wr_en;
	} dcsl_regs_type;

	dcsl_regs_type r_q;
	dcsl_regs_type r_d;

	// Picks the selected unit's bit from a per-unit report vector.
	function automatic logic unit_bit(input logic [UNITS-1:0] v,
			input logic [2:0] u);
		unit_bit = v[u];
	endfunction

	// Merges write data into a register value under the byte enables.
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] m;
		m = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		be_merge = m;
	endfunction

	// Scratch values of the next-state process, set on every pass.
	logic        req;
	logic        take_write;
	logic        lock_hit;
	logic        write_fence;
	logic [31:0] wv;
	logic [31:0] status_word;
	logic [6:0]  state_bits;
	logic [7:0]  attn_clr;

	// Next-state logic for the whole block.
	always_comb begin
		r_d = r_q;
		req = AVS_READ_IN | AVS_WRITE_IN;
		take_write = AVS_WRITE_IN & ~r_q.waitreq;
		wv = 32'h00000000;
		attn_clr = 8'h00;

		// Lockout compare; limit is live only with the switch engaged.
		lock_hit = LOCKOUT_SW_IN && (r_q.unit_sel == PROTECTED_UNIT_IN);
		// The fence leaves the unit out: a go may name a new unit.
		write_fence = LOCKOUT_SW_IN &&
			(r_q.cyl <= {5'h00, PROTECT_LIMIT_CYL_IN});

		// Selected unit status is resampled each cycle.
		r_d.online    = unit_bit(DRV_ONLINE_IN, r_q.unit_sel);
		r_d.ready     = unit_bit(DRV_READY_IN, r_q.unit_sel);
		r_d.seeking   = unit_bit(DRV_SEEKING_IN, r_q.unit_sel);
		r_d.read_only = unit_bit(DRV_READ_ONLY_IN, r_q.unit_sel);
		r_d.blocked   = lock_hit &&
			(r_q.cyl < {5'h00, PROTECT_LIMIT_CYL_IN});
		r_d.drv_pos   = DRV_HEAD_POS_IN;

		// Status word seen by software. Unit bits are one cycle old, which
		// keeps the read path short; switch bits are read live.
		status_word = 32'h00000000;
		status_word[dcsl_pkg::ST_ONLINE]  = r_q.online;
		status_word[dcsl_pkg::ST_READY]   = r_q.ready;
		status_word[dcsl_pkg::ST_SEEK]    = r_q.seeking;
		status_word[dcsl_pkg::ST_RO]      = r_q.read_only;
		status_word[dcsl_pkg::ST_BLOCKED] = r_q.blocked;
		status_word[dcsl_pkg::ST_FORMAT]  = FORMAT_SW_IN;
		status_word[dcsl_pkg::ST_NORMAL]  = ~FORMAT_SW_IN;
		status_word[dcsl_pkg::ST_LOCKOUT] = LOCKOUT_SW_IN;
		status_word[dcsl_pkg::ST_ATTN]    = r_q.attn_any;
		status_word[dcsl_pkg::ST_BUSY]    = r_q.busy;
		status_word[dcsl_pkg::ST_WP_ERR]  = r_q.wp_err;

		// One-hot picture of the control state.
		state_bits = 7'h00;
		state_bits[r_q.state] = 1'b1;

		// Bus handshake: answer one cycle after the request appears.
		// Waitrequest is low one cycle only; a held request is served again every second cycle.
		if (req && r_q.waitreq) begin
			r_d.waitreq = 1'b0;
			case (AVS_ADDRESS_IN)
				dcsl_pkg::ADDR_CTRL:
					r_d.rdata = {23'h000000, 3'h0, r_q.func, r_q.unit_sel};
				dcsl_pkg::ADDR_MEM_ADDR:
					r_d.rdata = {15'h0000, r_q.mem_addr};
				dcsl_pkg::ADDR_CYL:
					r_d.rdata = {24'h000000, r_q.cyl};
				dcsl_pkg::ADDR_HEAD:
					r_d.rdata = {27'h0000000, r_q.head};
				dcsl_pkg::ADDR_SECTOR:
					r_d.rdata = {28'h0000000, r_q.sector};
				dcsl_pkg::ADDR_STATUS:
					r_d.rdata = status_word;
				dcsl_pkg::ADDR_PROTECT:
					r_d.rdata = {26'h0000000, PROTECT_LIMIT_CYL_IN,
						PROTECTED_UNIT_IN};
				dcsl_pkg::ADDR_DRIVE_POS:
					r_d.rdata = {24'h000000, r_q.drv_pos};
				dcsl_pkg::ADDR_ATTN:
					r_d.rdata = {24'h000000, r_q.attn};
				dcsl_pkg::ADDR_SWC:
					r_d.rdata = {24'h000000, r_q.swc_ovf, r_q.sector_word_counter};
				dcsl_pkg::ADDR_FORMAT_SEQUENCER_STATE:
					r_d.rdata = {23'h000000, r_q.format_sequencer_state};
				dcsl_pkg::ADDR_STATE:
					r_d.rdata = {25'h0000000, state_bits};
				default:
					r_d.rdata = 32'h00000000;
			endcase
		end else begin
			r_d.waitreq = 1'b1;
		end

		// Register writes land at the edge that sees waitrequest low.
		if (take_write) begin
			case (AVS_ADDRESS_IN)
				dcsl_pkg::ADDR_CTRL: begin
					wv = be_merge({23'h000000, 3'h0, r_q.func, r_q.unit_sel},
						AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
					// Unit and function cannot change under a running job.
					if (r_q.state == dcsl_pkg::ST_IDLE) begin
						r_d.unit_sel = wv[dcsl_pkg::CTRL_UNIT_LSB +: 3];
						r_d.func     = wv[dcsl_pkg::CTRL_FUNC_LSB +: 3];
					end
				end
				dcsl_pkg::ADDR_MEM_ADDR: begin
					wv = be_merge({15'h0000, r_q.mem_addr},
						AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
					if (r_q.state == dcsl_pkg::ST_IDLE) begin
						r_d.mem_addr = wv[16:0];
					end
				end
				dcsl_pkg::ADDR_CYL: begin
					wv = be_merge({24'h000000, r_q.cyl},
						AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
					if (r_q.state == dcsl_pkg::ST_IDLE) begin
						r_d.cyl = wv[7:0];
					end
				end
				dcsl_pkg::ADDR_HEAD: begin
					wv = be_merge({27'h0000000, r_q.head},
						AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
					if (r_q.state == dcsl_pkg::ST_IDLE) begin
						r_d.head = wv[4:0];
					end
				end
				dcsl_pkg::ADDR_SECTOR: begin
					wv = be_merge({28'h0000000, r_q.sector},
						AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
					if (r_q.state == dcsl_pkg::ST_IDLE) begin
						r_d.sector = wv[3:0];
					end
				end
				dcsl_pkg::ADDR_ATTN: begin
					// Write one to clear; byte lane 0 carries all eight units.
					if (AVS_BYTEENABLE_IN[0]) begin
						attn_clr = AVS_WRITEDATA_IN[7:0];
					end
				end
				default: begin
					wv = 32'h00000000;
				end
			endcase
		end

		// Attention: a completion in the clearing cycle still sets the bit.
		r_d.attn = (r_q.attn & ~attn_clr) | DRV_POS_DONE_IN;
		r_d.attn_any = |r_d.attn;

		// Control state sequencing.
		case (r_q.state)
			dcsl_pkg::ST_IDLE: begin
				if (take_write && AVS_ADDRESS_IN == dcsl_pkg::ADDR_CTRL &&
						AVS_BYTEENABLE_IN[1] &&
						AVS_WRITEDATA_IN[dcsl_pkg::CTRL_GO_BIT]) begin
					// Each go clears the error, so it reports the last command.
					r_d.wp_err = 1'b0;
					case (wv[dcsl_pkg::CTRL_FUNC_LSB +: 3])
						dcsl_pkg::FN_READ: begin
							r_d.state = dcsl_pkg::ST_HEAD_RESET_STATE;
						end
						dcsl_pkg::FN_WRITE: begin
							// A fenced write never leaves idle; the unit
							// checked is the one named by this same write.
							if (write_fence &&
									wv[dcsl_pkg::CTRL_UNIT_LSB +: 3] ==
									PROTECTED_UNIT_IN) begin
								r_d.wp_err = 1'b1;
							end else begin
								r_d.state = dcsl_pkg::ST_HEAD_RESET_STATE;
							end
						end
						dcsl_pkg::FN_RECAL: begin
							r_d.state = dcsl_pkg::ST_RECAL_GO;
						end
						dcsl_pkg::FN_SEEK: begin
							r_d.state = dcsl_pkg::ST_SEEK_GO;
						end
						default: begin
							r_d.state = dcsl_pkg::ST_IDLE;
						end
					endcase
				end
			end
			dcsl_pkg::ST_HEAD_RESET_STATE: begin
				// Drive drops its head select; a new sector count begins.
				r_d.sector_word_counter = 7'h00;
				r_d.swc_ovf = 1'b0;
				r_d.format_sequencer_state = 9'h000;
				r_d.state = (r_q.func == dcsl_pkg::FN_WRITE) ?
					dcsl_pkg::ST_WRITE : dcsl_pkg::ST_READ;
			end
			dcsl_pkg::ST_READ, dcsl_pkg::ST_WRITE: begin
				if (WORD_STROBE_IN) begin
					r_d.sector_word_counter = r_q.sector_word_counter + 7'h01;
					// One counted word is two processor words.
					r_d.mem_addr = r_q.mem_addr + dcsl_pkg::MEM_ADDR_STEP;
					// Format sequencing only runs when writing in format mode.
					if (FORMAT_SW_IN && r_q.state == dcsl_pkg::ST_WRITE) begin
						r_d.format_sequencer_state = r_q.format_sequencer_state + 9'h001;
					end
					if (r_q.sector_word_counter == dcsl_pkg::SWC_MAX) begin
						r_d.swc_ovf = 1'b1;
						r_d.state = dcsl_pkg::ST_INC_HEAD;
					end
				end
				// Software stops a transfer by writing function idle with go.
				if (take_write && AVS_ADDRESS_IN == dcsl_pkg::ADDR_CTRL &&
						AVS_BYTEENABLE_IN[0] && AVS_BYTEENABLE_IN[1] &&
						AVS_WRITEDATA_IN[dcsl_pkg::CTRL_GO_BIT] &&
						AVS_WRITEDATA_IN[dcsl_pkg::CTRL_FUNC_LSB +: 3] ==
						dcsl_pkg::FN_IDLE) begin
					r_d.state = dcsl_pkg::ST_IDLE;
				end
			end
			dcsl_pkg::ST_INC_HEAD: begin
				// Next surface; the sector counter restarts for it. A word
				// strobe in this cycle is not counted, so the data path must
				// leave one idle cycle at each head change. The format count
				// runs on across the change.
				r_d.head = r_q.head + 5'h01;
				r_d.sector_word_counter = 7'h00;
				r_d.swc_ovf = 1'b0;
				r_d.state = (r_q.func == dcsl_pkg::FN_WRITE) ?
					dcsl_pkg::ST_WRITE : dcsl_pkg::ST_READ;
			end
			dcsl_pkg::ST_SEEK_GO, dcsl_pkg::ST_RECAL_GO: begin
				// Positioning runs in the drive; the controller goes idle
				// and learns of the end through the drive's done pulse.
				r_d.state = dcsl_pkg::ST_IDLE;
			end
			default: begin
				r_d.state = dcsl_pkg::ST_IDLE;
			end
		endcase

		r_d.busy = (r_d.state != dcsl_pkg::ST_IDLE);

		// Drive strobes follow the next state so they line up with it.
		r_d.head_clr  = (r_d.state == dcsl_pkg::ST_HEAD_RESET_STATE);
		r_d.head_step = (r_d.state == dcsl_pkg::ST_INC_HEAD);
		r_d.seek_go   = (r_d.state == dcsl_pkg::ST_SEEK_GO);
		r_d.recal_go  = (r_d.state == dcsl_pkg::ST_RECAL_GO);
		r_d.rd_en     = (r_d.state == dcsl_pkg::ST_READ);
		r_d.wr_en     = (r_d.state == dcsl_pkg::ST_WRITE);
	end

	// Single register stage for all state.
	always_ff @(posedge CLOCK_IN) begin
		if (SRST_IN) begin
			// Blanket clear, then the fields whose reset value is named.
			r_q <= '0;
			r_q.state <= dcsl_pkg::ST_IDLE;
			r_q.mem_addr <= dcsl_pkg::MEM_ADDR_RST;
			r_q.waitreq <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end

	// Outputs straight from the state register.
	assign AVS_READDATA_OUT       = r_q.rdata;
	assign AVS_WAITREQUEST_OUT    = r_q.waitreq;
	assign UNIT_SELECT_OUT        = r_q.unit_sel;
	assign CYLINDER_ADDRESS_OUT   = r_q.cyl;
	assign HEAD_ADDRESS_OUT       = r_q.head;
	assign MEMORY_ADDRESS_OUT     = r_q.mem_addr;
	assign HEAD_CLEAR_OUT         = r_q.head_clr;
	assign HEAD_STEP_OUT          = r_q.head_step;
	assign SEEK_START_OUT         = r_q.seek_go;
	assign RECAL_START_OUT        = r_q.recal_go;
	assign READ_ENABLE_OUT        = r_q.rd_en;
	assign WRITE_ENABLE_OUT       = r_q.wr_en;
	assign BUSY_OUT               = r_q.busy;
	assign ATTENTION_OUT          = r_q.attn_any;
	assign UNIT_WRITE_BLOCKED_OUT = r_q.blocked;

endmodule // dcsl_top

// *** rtl/dcsl_pkg.sv ***
// Function
// - Online status is true while the selected drive is powered and switched on line.
// - Ready status follows the selected drive's ready-for-transfer report.
// - Seek status is true while the selected drive is positioning.
// - Read-only status follows the selected drive's read-only console switch.
// - Locked-out status: lockout on, unit equals protected unit, cylinder below limit.
// - Protection limit is a three-bit switch value, used only with lockout on.
// - One status bit shows that the lockout switch is engaged.
// - Separate status bits show format position and normal position of switch.
// - Memory current address register holds address bits 1 through 17.
// - Eight-bit cylinder address register holds the commanded cylinder.
// - Five-bit head address register holds the addressed surface.
// - Four-bit sector address register holds the addressed sector.
// - Selected drive reports its eight-bit head cylinder; controller captures it.
// - Increment-head state deselects current head and selects the next one.
// - Idle is the only non-busy state; read, write, seek and recal states exist.
// - A unit's attention bit sets when it completes a positioning command.
// - Seven-bit counter counts double-length words moved within one sector.
// - Sector-count overflow flag rises when the sector word counter overflows.
// - Nine-bit format generator state register sequences sector formatting.
// - Overall attention flag is the OR of the eight unit attention bits.
package dcsl_pkg;

	// Register byte addresses on the Avalon-MM slave.
	localparam logic [5:0] ADDR_CTRL      = 6'h00;
	localparam logic [5:0] ADDR_MEM_ADDR  = 6'h04;
	localparam logic [5:0] ADDR_CYL       = 6'h08;
	localparam logic [5:0] ADDR_HEAD      = 6'h0C;
	localparam logic [5:0] ADDR_SECTOR    = 6'h10;
	localparam logic [5:0] ADDR_STATUS    = 6'h14;
	localparam logic [5:0] ADDR_PROTECT   = 6'h18;
	localparam logic [5:0] ADDR_DRIVE_POS = 6'h1C;
	localparam logic [5:0] ADDR_ATTN      = 6'h20;
	localparam logic [5:0] ADDR_SWC       = 6'h24;
	localparam logic [5:0] ADDR_FORMAT_SEQUENCER_STATE   = 6'h28;
	localparam logic [5:0] ADDR_STATE     = 6'h2C;

	// Control register fields.
	localparam int CTRL_UNIT_LSB = 0;
	localparam int CTRL_FUNC_LSB = 3;
	localparam int CTRL_GO_BIT   = 8;

	// Status register bit positions.
	localparam int ST_ONLINE  = 0;
	localparam int ST_READY   = 1;
	localparam int ST_SEEK    = 2;
	localparam int ST_RO      = 3;
	localparam int ST_BLOCKED = 4;
	localparam int ST_FORMAT  = 5;
	localparam int ST_NORMAL  = 6;
	localparam int ST_LOCKOUT = 7;
	localparam int ST_ATTN    = 8;
	localparam int ST_BUSY    = 9;
	localparam int ST_WP_ERR  = 10;

	// Function codes written to the control register.
	localparam logic [2:0] FN_IDLE  = 3'h0;
	localparam logic [2:0] FN_READ  = 3'h1;
	localparam logic [2:0] FN_WRITE = 3'h2;
	localparam logic [2:0] FN_RECAL = 3'h3;
	localparam logic [2:0] FN_SEEK  = 3'h4;

	// Reset values, counting steps and the counter limit.
	localparam logic [16:0] MEM_ADDR_RST  = 17'h00000;
	localparam logic [16:0] MEM_ADDR_STEP = 17'h00002;
	localparam logic [6:0]  SWC_MAX       = 7'h7F;

	// Control states.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_HEAD_RESET_STATE,
		ST_READ,
		ST_WRITE,
		ST_INC_HEAD,
		ST_SEEK_GO,
		ST_RECAL_GO
	} dcsl_state_type;

endpackage

// *** verification/dcsl_props.sv ***
`timescale 1ns/1ps
module dcsl_props #(
	parameter int UNITS = 8
) (
	// Clock and reset.
	input wire logic             CLOCK_IN,
	input wire logic             SRST_IN,
	// Bus and switches.
	input wire logic             AVS_READ_IN,
	input wire logic             AVS_WRITE_IN,
	input wire logic             AVS_WAITREQUEST_OUT,
	input wire logic             LOCKOUT_SW_IN,
	input wire logic [2:0]       PROTECTED_UNIT_IN,
	input wire logic [2:0]       PROTECT_LIMIT_CYL_IN,
	// Drive side.
	input wire logic [UNITS-1:0] DRV_POS_DONE_IN,
	input wire logic             WORD_STROBE_IN,
	input wire logic [2:0]       UNIT_SELECT_OUT,
	input wire logic [7:0]       CYLINDER_ADDRESS_OUT,
	input wire logic [4:0]       HEAD_ADDRESS_OUT,
	input wire logic [16:0]      MEMORY_ADDRESS_OUT,
	input wire logic             HEAD_CLEAR_OUT,
	input wire logic             HEAD_STEP_OUT,
	input wire logic             SEEK_START_OUT,
	input wire logic             RECAL_START_OUT,
	input wire logic             READ_ENABLE_OUT,
	input wire logic             WRITE_ENABLE_OUT,
	input wire logic             BUSY_OUT,
	input wire logic             ATTENTION_OUT,
	input wire logic             UNIT_WRITE_BLOCKED_OUT
);
	// One clock domain, so clocking and reset are given once.
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (SRST_IN);

	// The blocked flag is a registered copy of the lockout comparison.
	blocked_calc_a: assert property (!$past(SRST_IN) |->
		UNIT_WRITE_BLOCKED_OUT == ($past(LOCKOUT_SW_IN) &&
		$past(UNIT_SELECT_OUT) == $past(PROTECTED_UNIT_IN) &&
		$past(CYLINDER_ADDRESS_OUT) <
		{5'h00, $past(PROTECT_LIMIT_CYL_IN)}))
		else $error("blocked flag wrong");
	attn_set_a: assert property (
		|DRV_POS_DONE_IN |-> ##[1:2] ATTENTION_OUT)
		else $error("attention not raised");
	head_reset_state_a: assert property (
		HEAD_CLEAR_OUT |=> !HEAD_CLEAR_OUT &&
		(READ_ENABLE_OUT || WRITE_ENABLE_OUT))
		else $error("clear head pulse wrong");
	xfer_entry_a: assert property (
		(READ_ENABLE_OUT || WRITE_ENABLE_OUT) && !$past(READ_ENABLE_OUT) &&
		!$past(WRITE_ENABLE_OUT) |->
		$past(HEAD_CLEAR_OUT) || $past(HEAD_STEP_OUT))
		else $error("transfer entered without head command");
	head_step_a: assert property (
		$past(HEAD_STEP_OUT) |->
		HEAD_ADDRESS_OUT == $past(HEAD_ADDRESS_OUT, 2) + 5'h01)
		else $error("head not stepped");
	xfer_busy_a: assert property (
		(READ_ENABLE_OUT || WRITE_ENABLE_OUT) |->
		BUSY_OUT && !(READ_ENABLE_OUT && WRITE_ENABLE_OUT))
		else $error("transfer state not busy");
	pos_pulse_a: assert property (
		(SEEK_START_OUT || RECAL_START_OUT) |=>
		!SEEK_START_OUT && !RECAL_START_OUT &&
		!READ_ENABLE_OUT && !WRITE_ENABLE_OUT)
		else $error("seek start not a pulse");
	mem_step_a: assert property (
		WORD_STROBE_IN && (READ_ENABLE_OUT || WRITE_ENABLE_OUT) |=>
		MEMORY_ADDRESS_OUT == $past(MEMORY_ADDRESS_OUT) + 17'h00002)
		else $error("memory address step wrong");
	bus_answer_a: assert property (
		(AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=>
		!AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT)
		else $error("bus answer timing wrong");
	reset_clear_a: assert property (
		disable iff (1'b0) SRST_IN |=> !BUSY_OUT && !ATTENTION_OUT &&
		AVS_WAITREQUEST_OUT && !UNIT_WRITE_BLOCKED_OUT)
		else $error("reset did not clear");

	// Main scenarios reached.
	cover property (WRITE_ENABLE_OUT);
	cover property (HEAD_STEP_OUT);
	cover property (UNIT_WRITE_BLOCKED_OUT);
	cover property (SEEK_START_OUT);
endmodule // dcsl_props

bind dcsl_top dcsl_props #(.UNITS(UNITS)) u_props (.*);

// *** verification/dcsl_drive_model.sv ***
`timescale 1ns/1ps
module dcsl_drive_model #(
	parameter logic [7:0] ONLINE = 8'h5A,
	parameter logic [7:0] READY  = 8'hC3,
	parameter logic [7:0] RO     = 8'h0F,
	parameter int         DELAY  = 20
) (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic [2:0] unit_in,
	input  wire logic [7:0] cyl_in,
	input  wire logic       seek_in,
	input  wire logic       recal_in,
	output logic [7:0]      online_out,
	output logic [7:0]      ready_out,
	output logic [7:0]      ro_out,
	output logic [7:0]      seeking_out,
	output logic [7:0]      done_out,
	output logic [7:0]      pos_out
);
	int         cnt;
	logic [2:0] u;
	logic [7:0] pos [8];

	// Console switches are fixed for the whole run.
	assign online_out = ONLINE;
	assign ready_out  = READY;
	assign ro_out     = RO;
	assign pos_out    = pos[unit_in];

	// Positioning takes DELAY cycles, then one done pulse is given.
	always_ff @(posedge clk_in) begin
		done_out <= 8'h00;
		if (rst_in) begin
			cnt         <= 0;
			seeking_out <= 8'h00;
			for (int i = 0; i < 8; i++) pos[i] <= 8'h00;
		end else if (seek_in || recal_in) begin
			u                    <= unit_in;
			cnt                  <= DELAY;
			seeking_out[unit_in] <= 1'b1;
			pos[unit_in]         <= seek_in ? cyl_in : 8'h00;
		end else if (cnt == 1) begin
			done_out[u]    <= 1'b1;
			seeking_out[u] <= 1'b0;
			cnt            <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule // dcsl_drive_model

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	localparam logic [7:0] ONL = 8'h5A;
	localparam logic [7:0] RDY = 8'hC3;
	localparam logic [7:0] RO  = 8'h0F;
	logic clk, srst, rd, wr, lk, fmt, ws, waitq, hclr, hstp, skg, rcg;
	logic re, we, busy, attn, blk;
	logic [5:0]  adr;
	logic [31:0] wdat, rdat, q;
	logic [2:0]  pu, pl, usel;
	logic [7:0]  onl, rdy, sk, ro, done, pos, cyl;
	logic [4:0]  head;
	logic [16:0] mem;
	int n_fail = 0, checks = 0, cyc = 0;
	logic [5:0]  ta [4] = '{6'h04, 6'h08, 6'h0C, 6'h10};
	logic [31:0] td [4] = '{32'h1ABCD, 32'hA5, 32'h03, 32'h0C};

	dcsl_top uut (.CLOCK_IN(clk), .SRST_IN(srst), .AVS_ADDRESS_IN(adr),
		.AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat),
		.AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdat),
		.AVS_WAITREQUEST_OUT(waitq), .LOCKOUT_SW_IN(lk),
		.PROTECTED_UNIT_IN(pu), .PROTECT_LIMIT_CYL_IN(pl), .FORMAT_SW_IN(fmt),
		.DRV_ONLINE_IN(onl), .DRV_READY_IN(rdy), .DRV_SEEKING_IN(sk),
		.DRV_READ_ONLY_IN(ro), .DRV_POS_DONE_IN(done), .DRV_HEAD_POS_IN(pos),
		.WORD_STROBE_IN(ws), .UNIT_SELECT_OUT(usel), .CYLINDER_ADDRESS_OUT(cyl),
		.HEAD_ADDRESS_OUT(head), .MEMORY_ADDRESS_OUT(mem),
		.HEAD_CLEAR_OUT(hclr), .HEAD_STEP_OUT(hstp), .SEEK_START_OUT(skg),
		.RECAL_START_OUT(rcg), .READ_ENABLE_OUT(re), .WRITE_ENABLE_OUT(we),
		.BUSY_OUT(busy), .ATTENTION_OUT(attn), .UNIT_WRITE_BLOCKED_OUT(blk));
	dcsl_drive_model #(.ONLINE(ONL), .READY(RDY), .RO(RO), .DELAY(20)) drv (
		.clk_in(clk), .rst_in(srst), .unit_in(usel), .cyl_in(cyl),
		.seek_in(skg), .recal_in(rcg), .online_out(onl), .ready_out(rdy),
		.ro_out(ro), .seeking_out(sk), .done_out(done), .pos_out(pos));

	// Free-running 200 MHz clock.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// A hang is cut short well past the expected run of under a thousand cycles.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			test_done;
		end
	end

	task test_done;
		if (n_fail == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Request held until waitrequest is seen low at a rising edge.
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		rd   <= !w;
		wr   <= w;
		adr  <= a;
		wdat <= d;
		do @(posedge clk); while (waitq !== 1'b0);
		q  = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task rdc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk($sformatf("reg_%h", a), e, q & m);
	endtask

	task ctl(input logic [2:0] fn, input logic [2:0] u, input logic go);
		bus(1'b1, dcsl_pkg::ADDR_CTRL, {23'h0, go, 2'b00, fn, u});
		repeat (2) @(posedge clk);
	endtask

	task wait_attn;
		for (int i = 0; i < 100 && attn !== 1'b1; i++) @(posedge clk);
		chk("attention", 32'h1, {31'h0, attn});
	endtask

	// Main sequence of scenarios.
	initial begin
		{rd, wr, lk, fmt, ws, adr, wdat, pu, pl} = '0;
		srst = 1'b1;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		for (int u = 0; u < 8; u++) begin
			ctl(dcsl_pkg::FN_IDLE, u[2:0], 1'b0);
			rdc(dcsl_pkg::ADDR_STATUS, 32'hFFFF,
				{25'h0, 3'h4, RO[u], 1'b0, RDY[u], ONL[u]});
		end
		fmt <= 1'b1;
		lk  <= 1'b1;
		pu  <= 3'h3;
		pl  <= 3'h5;
		ctl(dcsl_pkg::FN_IDLE, 3'h3, 1'b0);
		bus(1'b1, dcsl_pkg::ADDR_CYL, 32'h4);
		rdc(dcsl_pkg::ADDR_STATUS, 32'hF0, 32'hB0);
		chk("write_blocked", 32'h1, {31'h0, blk});
		chk("unit_select", 32'h3, {29'h0, usel});
		bus(1'b1, dcsl_pkg::ADDR_CYL, 32'h5);
		rdc(dcsl_pkg::ADDR_STATUS, 32'hF0, 32'hA0);
		chk("write_blocked", 32'h0, {31'h0, blk});
		rdc(dcsl_pkg::ADDR_PROTECT, 32'hFF, 32'h2B);
		ctl(dcsl_pkg::FN_WRITE, 3'h3, 1'b1);
		rdc(dcsl_pkg::ADDR_STATUS, 32'h600, 32'h400);
		chk("write_enable", 32'h0, {31'h0, we});
		lk <= 1'b0;
		for (int i = 0; i < 4; i++) bus(1'b1, ta[i], td[i]);
		bus(1'b1, 6'h30, 32'hFFFF);
		for (int i = 0; i < 4; i++)
			rdc(ta[i], 32'hFFFFFFFF, td[i]);
		rdc(6'h30, 32'hFFFFFFFF, 32'h0);
		chk("cyl_out", 32'hA5, {24'h0, cyl});
		chk("mem_out", 32'h1ABCD, {15'h0, mem});
		ctl(dcsl_pkg::FN_WRITE, 3'h1, 1'b1);
		rdc(dcsl_pkg::ADDR_STATE, 32'hFF, 32'h08);
		repeat (130) begin
			@(posedge clk) ws <= 1'b1;
			@(posedge clk) ws <= 1'b0;
			repeat (2) @(posedge clk);
		end
		rdc(dcsl_pkg::ADDR_HEAD, 32'h1F, 32'h04);
		rdc(dcsl_pkg::ADDR_MEM_ADDR, 32'h1FFFF, 32'h1ACD1);
		rdc(dcsl_pkg::ADDR_SWC, 32'h7F, 32'h02);
		rdc(dcsl_pkg::ADDR_FORMAT_SEQUENCER_STATE, 32'h1FF, 32'h82);
		ctl(dcsl_pkg::FN_IDLE, 3'h1, 1'b1);
		rdc(dcsl_pkg::ADDR_STATE, 32'hFF, 32'h01);
		ctl(dcsl_pkg::FN_READ, 3'h1, 1'b1);
		chk("read_enable", 32'h1, {31'h0, re});
		ctl(dcsl_pkg::FN_IDLE, 3'h1, 1'b1);
		bus(1'b1, dcsl_pkg::ADDR_CYL, 32'h77);
		ctl(dcsl_pkg::FN_SEEK, 3'h2, 1'b1);
		rdc(dcsl_pkg::ADDR_STATUS, 32'h4, 32'h4);
		wait_attn;
		rdc(dcsl_pkg::ADDR_ATTN, 32'hFF, 32'h04);
		rdc(dcsl_pkg::ADDR_DRIVE_POS, 32'hFF, 32'h77);
		bus(1'b1, dcsl_pkg::ADDR_ATTN, 32'h04);
		rdc(dcsl_pkg::ADDR_ATTN, 32'hFF, 32'h00);
		chk("attention_clear", 32'h0, {31'h0, attn});
		ctl(dcsl_pkg::FN_RECAL, 3'h5, 1'b1);
		wait_attn;
		rdc(dcsl_pkg::ADDR_ATTN, 32'hFF, 32'h20);
		rdc(dcsl_pkg::ADDR_DRIVE_POS, 32'hFF, 32'h00);
		test_done;
	end
endmodule // testbench
